// [design/thermal_clkout_cfg.svh]
// Constants of the thermal and slow-clock-output register pair
`ifndef THERMAL_CLKOUT_CFG_SVH
`define THERMAL_CLKOUT_CFG_SVH
`define ADDR_THERMAL 8'h22
`define ADDR_CLKOUT 8'h23
`define THERMAL_RESET 8'h0d
`define HDSEL_RESET 2'h3
`define MON_EN_RESET 1'h1
`define BIT_HOT_DIE 5
`define BIT_SHUTDOWN 4
`define BIT_HDSEL_HI 3
`define BIT_HDSEL_LO 2
`define BIT_MON_EN 0
`define BIT_CLK_EN 0
`endif

// [design/thermal_clkout_pkg.sv]
// Types shared by the thermal and slow-clock-output registers
package thermal_clkout_pkg;
  typedef enum logic [1:0] {
    hd_117c,
    hd_121c,
    hd_125c,
    hd_130c
  } hd_threshold_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage : thermal_clkout_pkg

// [design/thermal_and_clkout_regs.sv]
// Thermal status/control and slow clock output control registers
//
// Behaviour
// - Thermal register at 0x22 resets to 0x0d
// - Thermal bits 7-6 and 1 read zero
// - Bit 5 shows hot-die threshold reached
// - Bit 4 shows shutdown detector output
// - Bits 3-2 select hot-die threshold, reset 11
// - Bit 0 enables shutdown monitor, reset 1
// - Clock register bit 0 gates the slow clock onto the output pin
// - Clock register 0x23, upper bits zero, factory reset
// - Factory-marked fields load from nonvolatile configuration
// - Strap-marked fields load from pin strapping
`timescale 1ns/1ns
`include "thermal_clkout_cfg.svh"

module thermal_and_clkout_regs
  import thermal_clkout_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  // Register port from the serial interface
  input wire reg_req_t req,
  output logic [7:0] rdata,
  // Factory configuration, valid while power-on reset is released
  input wire logic otp_valid,
  input wire logic otp_clk_out_enable,
  // Analog detectors and oscillator
  input wire logic hot_die_detect,
  input wire logic shutdown_detect,
  input wire logic slow_clock_in,
  // Control toward the analog side
  output hd_threshold_t hot_die_threshold_select,
  output logic shutdown_monitor_enable,
  output logic slow_clock_output_pin
);

  // ==========================================================
  // Functions
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction : hit

  // ==========================================================
  // State
  logic hot_die_flag;
  logic overtemp_shutdown_flag;
  logic slow_clock_output_enable;
  logic otp_loaded;
  logic [7:0] thermal_status_control;
  logic [7:0] slow_clock_output_control;
  logic [7:0] next_rdata;

  // ==========================================================
  // Thermal control fields
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hot_die_threshold_select <= hd_threshold_t'(`HDSEL_RESET);
      shutdown_monitor_enable <= `MON_EN_RESET;
    end else if (clk_en && req.wr && hit(req.addr, `ADDR_THERMAL)) begin
      // Only the writable fields are taken from the write data
      hot_die_threshold_select <= hd_threshold_t'(req.wdata[`BIT_HDSEL_HI:`BIT_HDSEL_LO]);
      shutdown_monitor_enable <= req.wdata[`BIT_MON_EN];
    end
  end

  // ==========================================================
  // Detector status, registered so reads see a stable level
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hot_die_flag <= 1'b0;
      overtemp_shutdown_flag <= 1'b0;
    end else if (clk_en) begin
      hot_die_flag <= hot_die_detect;
      overtemp_shutdown_flag <= shutdown_detect;
    end
  end

  // ==========================================================
  // Clock output enable, factory value taken once after reset release
  // Async reset can only load a constant, so the factory value follows on otp_valid
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      slow_clock_output_enable <= 1'b0;
      otp_loaded <= 1'b0;
    end else if (clk_en) begin
      // No strap-marked field here, so only the factory value enters
      if (!otp_loaded && otp_valid) begin
        slow_clock_output_enable <= otp_clk_out_enable;
        otp_loaded <= 1'b1;
      end else if (req.wr && hit(req.addr, `ADDR_CLKOUT)) begin
        slow_clock_output_enable <= req.wdata[`BIT_CLK_EN];
      end
    end
  end

  // ==========================================================
  // Read path
  always_comb begin
    thermal_status_control = 8'h00;
    thermal_status_control[`BIT_HOT_DIE] = hot_die_flag;
    thermal_status_control[`BIT_SHUTDOWN] = overtemp_shutdown_flag;
    thermal_status_control[`BIT_HDSEL_HI:`BIT_HDSEL_LO] = hot_die_threshold_select;
    thermal_status_control[`BIT_MON_EN] = shutdown_monitor_enable;
    slow_clock_output_control = 8'h00;
    slow_clock_output_control[`BIT_CLK_EN] = slow_clock_output_enable;
    next_rdata = 8'h00;
    if (hit(req.addr, `ADDR_THERMAL)) begin
      next_rdata = thermal_status_control;
    end else if (hit(req.addr, `ADDR_CLKOUT)) begin
      next_rdata = slow_clock_output_control;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else if (clk_en && req.rd) begin
      rdata <= next_rdata;
    end
  end

  // Gated, not registered, so the pin follows the oscillator edge for edge
  assign slow_clock_output_pin = slow_clock_output_enable & slow_clock_in;

endmodule : thermal_and_clkout_regs

// [tb/host_model.sv]
// Host side model issuing register requests
`timescale 1ns/1ns
module host_model import thermal_clkout_pkg::*; (
  input wire logic clk_sys,
  input wire logic [7:0] rdata,
  output reg_req_t req
);
  initial req = '0;
  // One strobe cycle, read data taken after the strobe edge
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clk_sys);
    #2 req = '{a, d, w, !w};
    @(posedge clk_sys);
    #2 req = '0;
    q = rdata;
  endtask : xfer
endmodule : host_model

// [tb/reg_chk_sva.sv]
// Checker for the thermal and clock output registers
`timescale 1ns/1ns
module reg_chk import thermal_clkout_pkg::*; (
  input wire logic clk_sys, input wire logic rst_b, input wire logic clk_en,
  input wire reg_req_t req, input wire logic [7:0] rdata, input wire logic slow_clock_in,
  input wire hd_threshold_t hot_die_threshold_select, input wire logic shutdown_monitor_enable,
  input wire logic slow_clock_output_pin
);
  logic wr22, rd22, rd23, rdx;
  assign wr22 = clk_en && req.wr && req.addr == 8'h22;
  assign rd22 = clk_en && req.rd && req.addr == 8'h22;
  assign rd23 = clk_en && req.rd && req.addr == 8'h23;
  assign rdx = clk_en && req.rd && req.addr != 8'h22 && req.addr != 8'h23;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  chk_thr_write: assert property (
    wr22 |=> hot_die_threshold_select == $past(req.wdata[3:2])) else $error("threshold write lost");
  chk_thr_hold: assert property (
    !wr22 |=> $stable(hot_die_threshold_select)) else $error("threshold moved");
  chk_mon_write: assert property (
    wr22 |=> shutdown_monitor_enable == $past(req.wdata[0])) else $error("monitor write lost");
  chk_th_read: assert property (
    rd22 |=> rdata[3:2] == $past(hot_die_threshold_select)
    && rdata[0] == $past(shutdown_monitor_enable)) else $error("thermal readback");
  chk_th_rsvd: assert property (
    rd22 |=> rdata[7:6] == 2'h0 && rdata[1] == 1'h0) else $error("thermal reserved set");
  chk_ck_rsvd: assert property (
    rd23 |=> rdata[7:1] == 7'h00) else $error("clock reserved set");
  chk_odd_addr: assert property (
    rdx |=> rdata == 8'h00) else $error("odd address data");
  chk_pin_gate: assert property (
    !slow_clock_in |-> !slow_clock_output_pin) else $error("pin not gated");
  cover property (wr22);
  cover property (rd23 ##1 rdata[0]);
  cover property (slow_clock_output_pin);
endmodule : reg_chk
bind thermal_and_clkout_regs reg_chk u_chk(.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
  .req(req), .rdata(rdata), .slow_clock_in(slow_clock_in),
  .hot_die_threshold_select(hot_die_threshold_select),
  .shutdown_monitor_enable(shutdown_monitor_enable), .slow_clock_output_pin(slow_clock_output_pin));

// [tb/tb.sv]
// Testbench for the thermal and clock output registers
`timescale 1ns/1ns
module tb;
  import thermal_clkout_pkg::*;
  logic clk_sys = 0, rst_b = 0, hot = 0, sd = 0, slow = 0, ce = 1, otp_ce = 1;
  reg_req_t req;
  logic [7:0] rdata, q;
  hd_threshold_t thr;
  logic mon, pin;
  int err_total = 0, checked = 0;
  always #20 clk_sys = ~clk_sys;
  always #103 slow = ~slow;
  thermal_and_clkout_regs u_dut(.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(ce), .req(req),
    .rdata(rdata), .otp_valid(1'b1), .otp_clk_out_enable(otp_ce), .hot_die_detect(hot),
    .shutdown_detect(sd), .slow_clock_in(slow), .hot_die_threshold_select(thr),
    .shutdown_monitor_enable(mon), .slow_clock_output_pin(pin));
  host_model u_host(.clk_sys(clk_sys), .rdata(rdata), .req(req));
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : cmp
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    u_host.xfer(1'b0, a, 8'h00, q);
    cmp("rdata", e, q);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (4) @(posedge clk_sys);
    #2 rst_b = 1;
    rd(8'h22, 8'h0d);
    rd(8'h23, 8'h01);
    wr(8'h22, 8'hff);
    rd(8'h22, 8'h0d);
    hot = 1;
    sd = 1;
    wr(8'h22, 8'h00);
    rd(8'h22, 8'h30);
    cmp("monitor", 8'h00, {7'h00, mon});
    for (int k = 0; k < 4; k++) begin
      wr(8'h22, 8'(k << 2));
      cmp("threshold", 8'(k), {6'h00, thr});
    end
    wr(8'h23, 8'hfe);
    rd(8'h23, 8'h00);
    #103 cmp("pin", 8'h00, {7'h00, pin});
    wr(8'h23, 8'hff);
    rd(8'h23, 8'h01);
    #103 cmp("pin", {7'h00, slow}, {7'h00, pin});
    rd(8'h40, 8'h00);
    otp_ce = 0;
    rst_b = 0;
    #40 rst_b = 1;
    rd(8'h22, 8'h3d);
    rd(8'h23, 8'h00);
    ce = 0;
    wr(8'h22, 8'h00);
    cmp("frozen", 8'h01, {7'h00, mon});
    ce = 1;
    $display("register test done");
    summarize();
  end
endmodule : tb
